// ---- pkg/tes_pkg.sv ----
// constants for the 8-bit timer/event counter with square wave and pwm
// assumes a 32-bit axi4-lite slave port and one 20 MHz system clock
package tes_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_COUNTER = 8'h00;
  localparam logic [7:0] OFF_COMPARE = 8'h04;
  localparam logic [7:0] OFF_CLKSEL  = 8'h08;
  localparam logic [7:0] OFF_MODE    = 8'h0c;
  // mode_control_reg fields
  localparam int MB_OUT_EN   = 0;
  localparam int MB_INVERT   = 1;
  localparam int MB_FF_RESET = 2;
  localparam int MB_FF_SET   = 3;
  localparam int MB_PWM      = 6;
  localparam int MB_COUNT_EN = 7;
  // bits 2..5 always read as zero
  localparam logic [7:0] MODE_READ_MASK = 8'hc3;
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] COMPARE_RESET  = 8'h00;
  localparam logic [2:0] CLKSEL_RESET   = 3'h0;
  localparam logic [7:0] COUNT_ZERO     = 8'h00;
  localparam logic [7:0] COUNT_TOP      = 8'hff;
  // clock select codes
  localparam logic [2:0] SEL_EV_FALL = 3'h0;
  localparam logic [2:0] SEL_EV_RISE = 3'h1;
  // prescaler masks for codes 2..7: fx, /2, /4, /64, /256, /8192
  localparam int PRE_W = 13;
  localparam logic [PRE_W-1:0] MASK_DIV1    = 13'h0000;
  localparam logic [PRE_W-1:0] MASK_DIV2    = 13'h0001;
  localparam logic [PRE_W-1:0] MASK_DIV4    = 13'h0003;
  localparam logic [PRE_W-1:0] MASK_DIV64   = 13'h003f;
  localparam logic [PRE_W-1:0] MASK_DIV256  = 13'h00ff;
  localparam logic [PRE_W-1:0] MASK_DIV8192 = 13'h1fff;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // register selector
  typedef enum logic [2:0] {
    REG_COUNTER = 3'b000,
    REG_COMPARE = 3'b001,
    REG_CLKSEL  = 3'b010,
    REG_MODE    = 3'b011,
    REG_NONE    = 3'b100
  } tes_reg_t;
endpackage

// ---- verilog/tes_timer.sv ----
// 8-bit timer/event counter: interval, event count, square wave, pwm
// assumes axi4-lite master on aclk; event pin is asynchronous
// What this block does
// - select 00h falling, 01h rising event edge
// - count enable starts counting event pulses
// - match raises interrupt, clears counter, repeats
// - inversion enabled: output flop toggles per match
// - square frequency is 1 over 2t(N+1)
// - set/reset bits preset flop outside pwm
// - mode bit 6 selects pwm
// - pwm bit 1 picks active level
// - bit 0 enables output waveform
// - pwm inactive until overflow, active until match
// - stopping count makes pwm output inactive
// - pwm cycle 256 clocks, width N
// - pwm compare write buffered until overflow
// - compare read returns new value before transfer
// - first match may be up to one count clock early
// - count enable 0 clears and halts counter
// - output disabled holds pin low
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module tes_timer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins and event
  input  wire logic        event_input_pin,
  output logic             timer_output_pin,
  output logic             match_interrupt
);

  function automatic tes_pkg::tes_reg_t decode(input logic [7:0] a);
    unique case (a)
      tes_pkg::OFF_COUNTER: decode = tes_pkg::REG_COUNTER;
      tes_pkg::OFF_COMPARE: decode = tes_pkg::REG_COMPARE;
      tes_pkg::OFF_CLKSEL:  decode = tes_pkg::REG_CLKSEL;
      tes_pkg::OFF_MODE:    decode = tes_pkg::REG_MODE;
      default:              decode = tes_pkg::REG_NONE;
    endcase
  endfunction

  function automatic logic [tes_pkg::PRE_W-1:0] pre_mask(
    input logic [2:0] sel);
    unique case (sel)
      3'h2:    pre_mask = tes_pkg::MASK_DIV1;
      3'h3:    pre_mask = tes_pkg::MASK_DIV2;
      3'h4:    pre_mask = tes_pkg::MASK_DIV4;
      3'h5:    pre_mask = tes_pkg::MASK_DIV64;
      3'h6:    pre_mask = tes_pkg::MASK_DIV256;
      default: pre_mask = tes_pkg::MASK_DIV8192;
    endcase
  endfunction

  logic [7:0]               event_counter_reg;
  logic [7:0]               compare_value_reg;
  logic [7:0]               cmp_active_reg;
  logic [2:0]               clock_select_reg;
  logic [7:0]               mode_control_reg;
  logic                     out_ff_reg;
  logic                     pwm_level_reg;
  logic [tes_pkg::PRE_W-1:0] pre_reg;
  logic [2:0]               ev_sync_reg;
  logic [7:0]               awaddr_reg;
  logic [31:0]              wdata_reg;
  logic [3:0]               wstrb_reg;
  logic                     aw_have_reg;
  logic                     w_have_reg;

  logic                     count_enable;
  logic                     pwm_mode_select;
  logic                     invert_or_active_level;
  logic                     output_enable;
  logic                     tick;
  logic                     match;
  logic                     overflow;
  logic                     do_write;
  logic                     wr_lane0;
  tes_pkg::tes_reg_t        wr_sel;
  logic [7:0]               count_next;

  assign count_enable           = mode_control_reg[tes_pkg::MB_COUNT_EN];
  assign pwm_mode_select        = mode_control_reg[tes_pkg::MB_PWM];
  assign invert_or_active_level = mode_control_reg[tes_pkg::MB_INVERT];
  assign output_enable          = mode_control_reg[tes_pkg::MB_OUT_EN];
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_sel   = decode(awaddr_reg);
  assign wr_lane0 = do_write && wstrb_reg[0];
  assign count_next = event_counter_reg + 8'h01;

  // event pin synchroniser, third stage for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ev_sync_reg <= 3'h0;
    else
      ev_sync_reg <= {ev_sync_reg[1:0], event_input_pin};
  end

  // free-running prescaler; start is not aligned to it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_reg <= '0;
    else
      pre_reg <= pre_reg + 13'h0001;
  end

  // count clock: event edge or prescaled system clock
  always_comb
  begin
    unique case (clock_select_reg)
      tes_pkg::SEL_EV_FALL: tick = ev_sync_reg[2] && !ev_sync_reg[1];
      tes_pkg::SEL_EV_RISE: tick = !ev_sync_reg[2] && ev_sync_reg[1];
      default: tick = (pre_reg & pre_mask(clock_select_reg))
                      == pre_mask(clock_select_reg);
    endcase
  end

  assign match    = tick && count_enable && !pwm_mode_select
                    && event_counter_reg == cmp_active_reg;
  assign overflow = tick && count_enable && pwm_mode_select
                    && event_counter_reg == tes_pkg::COUNT_TOP;

  // counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      event_counter_reg <= tes_pkg::COUNT_ZERO;
    else if (!count_enable)
      event_counter_reg <= tes_pkg::COUNT_ZERO;
    else if (match)
      event_counter_reg <= tes_pkg::COUNT_ZERO;
    else if (tick)
      event_counter_reg <= count_next;
  end

  // interrupt pulse on each match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      match_interrupt <= 1'b0;
    else
      match_interrupt <= match;
  end

  // compare register as software wrote it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      compare_value_reg <= tes_pkg::COMPARE_RESET;
    else if (wr_lane0 && wr_sel == tes_pkg::REG_COMPARE)
      compare_value_reg <= wdata_reg[7:0];
  end

  // compare value in use; in pwm with count enabled, transfers only at overflow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmp_active_reg <= tes_pkg::COMPARE_RESET;
    else if (!pwm_mode_select || !count_enable || overflow)
      cmp_active_reg <= compare_value_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clock_select_reg <= tes_pkg::CLKSEL_RESET;
    else if (wr_lane0 && wr_sel == tes_pkg::REG_CLKSEL)
      clock_select_reg <= wdata_reg[2:0];
  end

  // set/reset strobes are not stored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_control_reg <= tes_pkg::MODE_RESET;
    else if (wr_lane0 && wr_sel == tes_pkg::REG_MODE)
      mode_control_reg <= wdata_reg[7:0] & tes_pkg::MODE_READ_MASK;
  end

  // timer output flip-flop for non-pwm modes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_ff_reg <= 1'b0;
    else if (wr_lane0 && wr_sel == tes_pkg::REG_MODE && !wdata_reg[tes_pkg::MB_PWM]
             && wdata_reg[tes_pkg::MB_FF_SET] != wdata_reg[tes_pkg::MB_FF_RESET])
      out_ff_reg <= wdata_reg[tes_pkg::MB_FF_SET];
    else if (match && invert_or_active_level)
      out_ff_reg <= !out_ff_reg;
  end

  // pwm active phase: overflow to match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm_level_reg <= 1'b0;
    else if (!count_enable || !pwm_mode_select)
      pwm_level_reg <= 1'b0;
    else if (overflow)
      pwm_level_reg <= compare_value_reg != tes_pkg::COUNT_ZERO;
    else if (tick && count_next == cmp_active_reg)
      pwm_level_reg <= 1'b0;
  end

  // output pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_output_pin <= 1'b0;
    else if (!output_enable)
      timer_output_pin <= 1'b0;
    else if (pwm_mode_select)
      timer_output_pin <= pwm_level_reg ^ invert_or_active_level;
    else
      timer_output_pin <= out_ff_reg;
  end

  // axi write address and data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_reg    <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_reg    <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
      aw_have_reg <= 1'b0;
    else
      s_axi_awready <= !aw_have_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_reg   <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_reg    <= tes_pkg::RDATA_ZERO;
      wstrb_reg    <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
    end
    else if (s_axi_bvalid && s_axi_bready)
      w_have_reg <= 1'b0;
    else
      s_axi_wready <= !w_have_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tes_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == tes_pkg::REG_NONE) ? tes_pkg::RESP_SLVERR
                                                    : tes_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // axi read: one request, answer next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= tes_pkg::RDATA_ZERO;
      s_axi_rresp   <= tes_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= tes_pkg::RESP_OKAY;
      s_axi_rdata   <= tes_pkg::RDATA_ZERO;
      unique case (decode(s_axi_araddr))
        tes_pkg::REG_COUNTER: s_axi_rdata[7:0] <= event_counter_reg;
        tes_pkg::REG_COMPARE: s_axi_rdata[7:0] <= compare_value_reg;
        tes_pkg::REG_CLKSEL:  s_axi_rdata[2:0] <= clock_select_reg;
        tes_pkg::REG_MODE:    s_axi_rdata[7:0] <= mode_control_reg;
        tes_pkg::REG_NONE:    s_axi_rresp      <= tes_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid;
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  fall_edge_a: assert property (clock_select_reg == tes_pkg::SEL_EV_FALL
    && ev_sync_reg[2] && !ev_sync_reg[1] |-> tick)
    else $error("falling event edge not counted");
  count_step_a: assert property (count_enable && tick && !match
    && !overflow |=> event_counter_reg == $past(count_next))
    else $error("counter did not step on count clock");
  match_clear_a: assert property (match |=> event_counter_reg
    == tes_pkg::COUNT_ZERO && match_interrupt)
    else $error("match did not clear counter and interrupt");
  toggle_ff_a: assert property (match && invert_or_active_level
    && !wr_lane0 |=> out_ff_reg != $past(out_ff_reg))
    else $error("output flop did not toggle on match");
  stop_clear_a: assert property (!count_enable
    |=> event_counter_reg == tes_pkg::COUNT_ZERO)
    else $error("stopped counter not cleared");
  out_low_a: assert property (!output_enable |=> !timer_output_pin)
    else $error("disabled output not low");
  pwm_stop_a: assert property (pwm_mode_select && !count_enable
    ##1 pwm_mode_select && output_enable
    |=> timer_output_pin == $past(invert_or_active_level))
    else $error("stopped pwm output not inactive");
  pwm_buffer_a: assert property (pwm_mode_select && count_enable
    && !overflow |=> cmp_active_reg == $past(cmp_active_reg))
    else $error("pwm compare changed before overflow");
  pwm_rise_a: assert property (overflow
    && compare_value_reg != tes_pkg::COUNT_ZERO
    |=> pwm_level_reg ##1 timer_output_pin != invert_or_active_level
    || !output_enable)
    else $error("pwm not active after overflow");

  match_seen_c: cover property (match ##1 match_interrupt);
  pwm_period_c: cover property (overflow ##[1:300] !pwm_level_reg);
  toggle_seen_c: cover property (match && invert_or_active_level);
endmodule

// ---- sim/tes_event_src.sv ----
// event source on the event pin and a load on the timer output pin
// assumes the bench calls toggle() and that the event pin starts low
`timescale 1ns/1ps
module tes_event_src (
  // clock
  input  wire logic aclk,
  // pins
  output logic      event_input_pin,
  input  wire logic timer_output_pin
);
  logic load_last = 1'b0;
  int   load_rises = 0;

  // pin only driven here, the block only reads it
  initial event_input_pin = 1'b0;

  // load counts output rises
  always @(posedge aclk)
  begin
    load_last <= timer_output_pin;
    if (timer_output_pin === 1'b1 && load_last === 1'b0)
      load_rises <= load_rises + 1;
  end

  // n level changes, four clocks apart
  task automatic toggle(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge aclk);
      event_input_pin <= ~event_input_pin;
    end
  endtask
endmodule

// ---- sim/tb_tes_timer.sv ----
// self-checking bench for the 8-bit timer/event counter
// assumes axi4-lite access, one 20 MHz clock and the event source model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_tes_timer;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  wr_b;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        event_input_pin, timer_output_pin, match_interrupt;
  logic [31:0] rd_d;
  logic [1:0]  rd_r;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n, t0;

  tes_timer DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .event_input_pin(event_input_pin),
    .timer_output_pin(timer_output_pin), .match_interrupt(match_interrupt)
  );

  tes_event_src src (
    .aclk(aclk), .event_input_pin(event_input_pin),
    .timer_output_pin(timer_output_pin)
  );

  initial forever #25 aclk = ~aclk;

  task automatic summarize();
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count = fail_count + 1;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid === 1'b1 || s_axi_wvalid === 1'b1);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    wr_b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
    rd(a);
    `CHK(nm, {24'h000000, e}, rd_d)
  endtask

  task automatic wait_pin(input logic l);
    while (timer_output_pin !== l) @(posedge aclk);
  endtask

  // length of the next full stretch at level l
  task automatic width(input logic l);
    wait_pin(~l);
    wait_pin(l);
    n = 0;
    while (timer_output_pin === l)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic pin_is(input logic e, input string nm);
    repeat (2) @(posedge aclk);
    `CHK(nm, e, timer_output_pin)
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(tes_pkg::OFF_MODE, 8'h00, "mode reset");
    rchk(tes_pkg::OFF_COMPARE, 8'h00, "compare reset");
    rchk(tes_pkg::OFF_CLKSEL, 8'h00, "clksel reset");
    rd(8'h10);
    `CHK("unmapped resp", tes_pkg::RESP_SLVERR, rd_r)
    wr(8'h10, 32'h0000_0000);
    `CHK("unmapped wresp", tes_pkg::RESP_SLVERR, wr_b)
    // event counting on both edge selections
    wr(tes_pkg::OFF_CLKSEL, 32'h01);
    wr(tes_pkg::OFF_COMPARE, 32'hff);
    wr(tes_pkg::OFF_MODE, 32'h80);
    src.toggle(6);
    repeat (8) @(posedge aclk);
    rchk(tes_pkg::OFF_COUNTER, 8'h03, "rise count");
    wr(tes_pkg::OFF_COUNTER, 32'h55);
    `CHK("counter wresp", tes_pkg::RESP_OKAY, wr_b)
    rchk(tes_pkg::OFF_COUNTER, 8'h03, "counter ro");
    wr(tes_pkg::OFF_MODE, 32'h00);
    rchk(tes_pkg::OFF_COUNTER, 8'h00, "stop clear");
    wr(tes_pkg::OFF_CLKSEL, 32'h00);
    wr(tes_pkg::OFF_MODE, 32'h80);
    src.toggle(5);
    repeat (8) @(posedge aclk);
    rchk(tes_pkg::OFF_COUNTER, 8'h02, "fall count");
    wr(tes_pkg::OFF_MODE, 32'h00);
    src.toggle(1);
    // interval on the undivided clock
    wr(tes_pkg::OFF_CLKSEL, 32'h02);
    wr(tes_pkg::OFF_COMPARE, 32'h04);
    wr(tes_pkg::OFF_MODE, 32'h80);
    while (match_interrupt !== 1'b1) @(posedge aclk);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (match_interrupt !== 1'b1);
    `CHK("match gap", 5, n)
    wr(tes_pkg::OFF_MODE, 32'h00);
    // square wave presets and toggling
    wr(tes_pkg::OFF_MODE, 32'h07);
    pin_is(1'b0, "preset low");
    wr(tes_pkg::OFF_MODE, 32'h0b);
    pin_is(1'b1, "preset high");
    rchk(tes_pkg::OFF_MODE, 8'h03, "mode read");
    wr(tes_pkg::OFF_MODE, 32'h0a);
    pin_is(1'b0, "output off");
    wr(tes_pkg::OFF_MODE, 32'h8b);
    width(1'b1);
    `CHK("square high", 5, n)
    width(1'b0);
    `CHK("square low", 5, n)
    wr(tes_pkg::OFF_MODE, 32'h00);
    // pwm, active high
    wr(tes_pkg::OFF_COMPARE, 32'h40);
    wr(tes_pkg::OFF_MODE, 32'h41);
    pin_is(1'b0, "pwm idle");
    wr(tes_pkg::OFF_MODE, 32'hc1);
    width(1'b1);
    `CHK("pwm active", 64, n)
    width(1'b0);
    `CHK("pwm inactive", 192, n)
    wait_pin(1'b0);
    wait_pin(1'b1);
    t0 = cyc;
    wr(tes_pkg::OFF_COMPARE, 32'h20);
    rchk(tes_pkg::OFF_COMPARE, 8'h20, "compare new");
    wait_pin(1'b0);
    `CHK("old width", 64, cyc - t0)
    width(1'b1);
    `CHK("new width", 32, n)
    wr(tes_pkg::OFF_MODE, 32'h41);
    pin_is(1'b0, "stop high");
    // pwm, active low
    wr(tes_pkg::OFF_MODE, 32'h43);
    pin_is(1'b1, "stop low");
    wr(tes_pkg::OFF_MODE, 32'hc3);
    width(1'b0);
    `CHK("pwm low", 32, n)
    wr(tes_pkg::OFF_MODE, 32'h42);
    pin_is(1'b0, "pwm off");
    // write with lane 0 strobe off is ignored
    s_axi_wstrb <= 4'h0;
    wr(tes_pkg::OFF_COMPARE, 32'h99);
    s_axi_wstrb <= 4'hf;
    rchk(tes_pkg::OFF_COMPARE, 8'h20, "lane off");
    summarize();
  end
endmodule
